// ==== hw/pser_pkg.sv ====
package pser_pkg;

  // ---------------------------------------------------------------
  // Register addresses (byte-free word index on the plain port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h1;
  localparam logic [3:0] ADDR_ON_SRC = 4'h2;
  localparam logic [3:0] ADDR_OFF_SRC = 4'h3;
  localparam logic [3:0] ADDR_STATE = 4'h4;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_CHIP_ON = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_SW_RESET = 2;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h0001;

  // ---------------------------------------------------------------
  // Configuration register fields
  // ---------------------------------------------------------------
  localparam int CFG_PIN_ON = 0;
  localparam int CFG_PIN_WAKE = 1;
  localparam int CFG_PIN_OFF = 2;
  localparam int CFG_WDOG_WAKE = 3;
  localparam int CFG_WDOG_RST = 4;
  localparam int CFG_PEN_WAKE = 5;
  localparam int CFG_LOW_WAKE = 6;
  localparam int CFG_LOW_OFF = 7;
  localparam int CFG_CHG_MASK = 8;
  localparam logic [15:0] CFG_RESET_VAL = 16'h0001;

  // ---------------------------------------------------------------
  // Power-up source bits
  // ---------------------------------------------------------------
  localparam int ON_WDOG_RST = 0;
  localparam int ON_HW_RST = 1;
  localparam int ON_SW_RST = 2;
  localparam int ON_CNV_UV = 3;
  localparam int ON_PIN = 4;
  localparam int ON_ALARM = 5;
  localparam int ON_SW_WAKE = 6;
  localparam int WATCHDOG_WAKE_SOURCE_FLAG = 7;
  localparam int ON_CHARGER = 8;
  localparam int ON_PEN = 9;
  localparam int ON_SUPPLY_LOW = 10;
  localparam int ON_GPIO = 11;
  localparam int ON_TRANSITION = 15;

  // ---------------------------------------------------------------
  // Power-off source bits
  // ---------------------------------------------------------------
  localparam int OFF_PIN = 4;
  localparam int OFF_SW = 6;
  localparam int OFF_THERMAL = 9;
  localparam int OFF_SUPPLY = 10;
  localparam int OFF_GPIO_B = 11;
  localparam int OFF_SEQ = 12;
  localparam int OFF_INT_REG = 13;

  localparam logic [15:0] ZERO16 = 16'h0000;

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PSER_OFF = 3'b001,
    PSER_ON = 3'b010,
    PSER_SLEEP = 3'b100
  } pser_state_t;

endpackage

// ==== hw/pser_router.sv ====
// Function
// - Alarm in OFF raises ON, sets transition and alarm flags.
// - GPIO power-on request raises ON, sets transition and GPIO flag.
// - Button set for ON raises ON, sets transition and button flag.
// - Writing sleep control zero wakes, sets software wake flag.
// - Any charger event wakes and sets charger wake flag.
// - Watchdog timeout wakes when so configured, sets its flag.
// - Alarm in SLEEP wakes and sets alarm flag.
// - Pen-down wakes when so configured, sets pen flag.
// - GPIO sleep/wake request wakes, sets GPIO on-source flag.
// - Supply undervoltage wakes when so configured, sets its flag.
// - Button set for WAKE wakes and sets button flag.
// - Four reset kinds go OFF then back ON if supply ok, recorded as reset flags.
// - Writing chip-on zero powers off, sets software off flag.
// - Button set for OFF powers off, sets button off flag.
// - Supply undervoltage powers off when so configured.
// - Supply below shutdown powers off unless a reset comes, same supply flag.
// - GPIO on/off request may power off, sets GPIO off flag.
// - Sequence start failure powers off, sets sequence flag.
// - Sleep control one or GPIO sleep request enters SLEEP.
// - Entering SLEEP and waking from it never touch the off-source register.
// - Power-up from OFF allowed only while supply exceeds the ok threshold.
// - Charging with mask set ignores user OFF requests.
// - Source flags show only the most recent event's cause.
`timescale 1ns/1ps

module pser_router
  import pser_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Event pulses from on-chip sources (same clock)
  input wire logic alarm_evt,
  input wire logic gpio_on_req,
  input wire logic gpio_off_req,
  input wire logic gpio_wake_req,
  input wire logic gpio_sleep_req,
  input wire logic charger_evt,
  input wire logic wdog_timeout_evt,
  input wire logic pen_down_evt,
  input wire logic supply_low_evt,
  input wire logic supply_shutdown_evt,
  input wire logic thermal_evt,
  input wire logic seq_fail_evt,
  input wire logic int_reg_fault_evt,
  input wire logic hw_reset_evt,
  input wire logic cnv_uv_reset_evt,
  // Levels from on-chip monitors
  input wire logic supply_ok,
  input wire logic charging,
  // Button pin, active low, asynchronous
  input wire logic button_n,
  // Transition requests and state
  output logic on_req,
  output logic wake_req,
  output logic off_req,
  output logic sleep_req,
  output logic [2:0] power_state
);

  // ---------------------------------------------------------------
  // Button synchroniser and edge detect
  // ---------------------------------------------------------------
  logic btn_meta_reg;
  logic btn_sync_reg;
  logic btn_last_reg;
  always_ff @(posedge clk)
  begin
    btn_meta_reg <= button_n;
    btn_sync_reg <= btn_meta_reg;
    btn_last_reg <= rst ? 1'b1 : btn_sync_reg;
  end
  // Press is a falling pin edge; idle-high reset level avoids a false press
  wire btn_press = btn_last_reg & ~btn_sync_reg;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] cfg_reg;
  logic [15:0] on_src_reg;
  logic [15:0] off_src_reg;
  logic [15:0] on_src_next;
  logic [15:0] off_src_next;
  pser_state_t state_reg;
  pser_state_t state_next;

  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_cfg = reg_wr && (reg_addr == ADDR_CFG);
  wire st_off = (state_reg == PSER_OFF);
  wire st_on = (state_reg == PSER_ON);
  wire st_sleep = (state_reg == PSER_SLEEP);

  // Software commands act on the written value, not on a stored change
  wire sw_off = wr_ctrl && !reg_wdata[CTRL_CHIP_ON] && !st_off;
  wire sw_sleep = wr_ctrl && reg_wdata[CTRL_SLEEP] && st_on;
  wire sw_wake = wr_ctrl && !reg_wdata[CTRL_SLEEP] && st_sleep;
  wire sw_reset = wr_ctrl && reg_wdata[CTRL_SW_RESET] && !st_off;

  wire user_off_mask = charging && cfg_reg[CFG_CHG_MASK];

  // ---------------------------------------------------------------
  // Per-source triggers
  // ---------------------------------------------------------------
  // alarm power-up
  wire t_on_alarm = alarm_evt && st_off;
  wire t_on_gpio = gpio_on_req && st_off;
  wire t_on_pin = btn_press && cfg_reg[CFG_PIN_ON] && st_off;

  wire t_w_alarm = alarm_evt && st_sleep;
  wire t_w_chg = charger_evt && st_sleep;
  wire t_w_wdog = wdog_timeout_evt && cfg_reg[CFG_WDOG_WAKE] && st_sleep;
  wire t_w_pen = pen_down_evt && cfg_reg[CFG_PEN_WAKE] && st_sleep;
  wire t_w_gpio = gpio_wake_req && st_sleep;
  wire t_w_low = supply_low_evt && cfg_reg[CFG_LOW_WAKE] && st_sleep;
  wire t_w_pin = btn_press && cfg_reg[CFG_PIN_WAKE] && st_sleep;

  wire t_r_wdog = wdog_timeout_evt && cfg_reg[CFG_WDOG_RST] && !st_off;
  wire t_r_hw = hw_reset_evt && !st_off;
  wire t_r_uv = cnv_uv_reset_evt && !st_off;
  wire any_reset = t_r_wdog || t_r_hw || sw_reset || t_r_uv;

  wire t_o_sw = sw_off && !user_off_mask;
  wire t_o_pin = btn_press && cfg_reg[CFG_PIN_OFF] && !st_off
                 && !user_off_mask;
  wire t_o_low = supply_low_evt && cfg_reg[CFG_LOW_OFF] && !st_off;
  wire t_o_shut = supply_shutdown_evt && !st_off;
  wire t_o_gpio = gpio_off_req && !st_off && !user_off_mask;
  wire t_o_seq = seq_fail_evt && !st_off;
  wire t_o_therm = thermal_evt && !st_off;
  wire t_o_int = int_reg_fault_evt && !st_off;

  wire any_off = t_o_sw || t_o_pin || t_o_low || t_o_shut || t_o_gpio
                 || t_o_seq || t_o_therm || t_o_int;
  wire any_on = (t_on_alarm || t_on_gpio || t_on_pin) && supply_ok;
  wire any_wake = t_w_alarm || t_w_chg || t_w_wdog || t_w_pen || t_w_gpio
                  || t_w_low || t_w_pin;
  wire any_sleep = (sw_sleep || (gpio_sleep_req && st_on)) && !any_off
                   && !any_reset;

  // Off and reset beat wake, wake beats sleep
  wire do_off = any_off && !any_reset;
  wire do_wake = any_wake && !do_off && !any_reset;

  // ---------------------------------------------------------------
  // Next state and source flags
  // ---------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    on_src_next = on_src_reg;
    off_src_next = off_src_reg;
    // reset returns to on while supply ok, else goes to off
    if (any_reset)
    begin
      state_next = supply_ok ? PSER_ON : PSER_OFF;
      on_src_next = ZERO16;
      on_src_next[ON_WDOG_RST] = t_r_wdog;
      on_src_next[ON_HW_RST] = t_r_hw;
      on_src_next[ON_SW_RST] = sw_reset;
      on_src_next[ON_CNV_UV] = t_r_uv;
    end
    else if (do_off)
    begin
      state_next = PSER_OFF;
      off_src_next = ZERO16;
      off_src_next[OFF_SW] = t_o_sw;
      off_src_next[OFF_PIN] = t_o_pin;
      off_src_next[OFF_SUPPLY] = t_o_low || t_o_shut;
      off_src_next[OFF_GPIO_B] = t_o_gpio;
      off_src_next[OFF_SEQ] = t_o_seq;
      off_src_next[OFF_THERMAL] = t_o_therm;
      off_src_next[OFF_INT_REG] = t_o_int;
    end
    else if (any_on)
    begin
      state_next = PSER_ON;
      on_src_next = ZERO16;
      on_src_next[ON_TRANSITION] = 1'b1;
      on_src_next[ON_ALARM] = t_on_alarm;
      on_src_next[ON_GPIO] = t_on_gpio;
      on_src_next[ON_PIN] = t_on_pin;
    end
    else if (do_wake)
    begin
      state_next = PSER_ON;
      on_src_next = ZERO16;
      on_src_next[ON_SW_WAKE] = sw_wake;
      on_src_next[ON_ALARM] = t_w_alarm;
      on_src_next[ON_CHARGER] = t_w_chg;
      on_src_next[WATCHDOG_WAKE_SOURCE_FLAG] = t_w_wdog;
      on_src_next[ON_PEN] = t_w_pen;
      on_src_next[ON_GPIO] = t_w_gpio;
      on_src_next[ON_SUPPLY_LOW] = t_w_low;
      on_src_next[ON_PIN] = t_w_pin;
    end
    else if (sw_wake)
    begin
      state_next = PSER_ON;
      on_src_next = ZERO16;
      on_src_next[ON_SW_WAKE] = 1'b1;
    end
    else if (any_sleep)
    begin
      state_next = PSER_SLEEP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= PSER_OFF;
      on_src_reg <= ZERO16;
      off_src_reg <= ZERO16;
    end
    else
    begin
      state_reg <= state_next;
      on_src_reg <= on_src_next;
      off_src_reg <= off_src_next;
    end
  end

  // ---------------------------------------------------------------
  // Control and configuration registers
  // ---------------------------------------------------------------
  // Reset bit is self-clearing so a read never shows a stale reset
  localparam logic [15:0] SW_RESET_MASK = 16'h0001 << CTRL_SW_RESET;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RESET_VAL;
      cfg_reg <= CFG_RESET_VAL;
    end
    else
    begin
      if (wr_cfg)
        cfg_reg <= reg_wdata;
      if (wr_ctrl)
        ctrl_reg <= reg_wdata & ~SW_RESET_MASK;
    end
  end

  // ---------------------------------------------------------------
  // Outputs and read port
  // ---------------------------------------------------------------
  logic on_req_reg;
  logic wake_req_reg;
  logic off_req_reg;
  logic sleep_req_reg;
  logic [15:0] rdata_reg;

  wire [15:0] rd_mux =
    (reg_addr == ADDR_CTRL) ? ctrl_reg :
    (reg_addr == ADDR_CFG) ? cfg_reg :
    (reg_addr == ADDR_ON_SRC) ? on_src_reg :
    (reg_addr == ADDR_OFF_SRC) ? off_src_reg :
    (reg_addr == ADDR_STATE) ? {13'h0000, state_reg} : ZERO16;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      on_req_reg <= 1'b0;
      wake_req_reg <= 1'b0;
      off_req_reg <= 1'b0;
      sleep_req_reg <= 1'b0;
      rdata_reg <= ZERO16;
    end
    else
    begin
      on_req_reg <= (any_on && !do_off) || (any_reset && supply_ok);
      wake_req_reg <= do_wake || (sw_wake && !do_off && !any_reset);
      off_req_reg <= do_off || any_reset;
      sleep_req_reg <= any_sleep && !any_on && !do_wake && !sw_wake;
      rdata_reg <= reg_rd ? rd_mux : ZERO16;
    end
  end

  assign on_req = on_req_reg;
  assign wake_req = wake_req_reg;
  assign off_req = off_req_reg;
  assign sleep_req = sleep_req_reg;
  assign reg_rdata = rdata_reg;
  assign power_state = state_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_alarm_on_flag: assert property (
    @(posedge clk) disable iff (rst)
    (alarm_evt && st_off && supply_ok && !any_reset && !any_off)
    |=> (on_src_reg[ON_TRANSITION] && on_src_reg[ON_ALARM] && on_req))
    else $error("alarm power-up not recorded");

  chk_supply_gate: assert property (
    @(posedge clk) disable iff (rst)
    (st_off && !supply_ok) |=> !on_req)
    else $error("power-up while supply not ok");

  chk_mask_user_off: assert property (
    @(posedge clk) disable iff (rst)
    (user_off_mask && sw_off && !t_o_pin && !t_o_low && !t_o_shut
     && !t_o_seq && !t_o_therm && !t_o_int && !any_reset)
    |=> !off_req)
    else $error("masked user off acted");

  chk_mask_gpio_off: assert property (
    @(posedge clk) disable iff (rst)
    (user_off_mask && gpio_off_req && !st_off && !sw_off && !t_o_pin
     && !t_o_low && !t_o_shut && !t_o_seq && !t_o_therm && !t_o_int
     && !any_reset)
    |=> !off_req)
    else $error("masked gpio off acted");

  chk_sleep_entry: assert property (
    @(posedge clk) disable iff (rst)
    (sw_sleep && !any_off && !any_reset)
    |=> (sleep_req && st_sleep))
    else $error("sleep request not taken");

  chk_sleep_keeps_off: assert property (
    @(posedge clk) disable iff (rst)
    (state_next == PSER_SLEEP && st_on) |=> $stable(off_src_reg))
    else $error("sleep changed off sources");

  chk_shutdown_off: assert property (
    @(posedge clk) disable iff (rst)
    (supply_shutdown_evt && !st_off && !any_reset)
    |=> (off_req && off_src_reg[OFF_SUPPLY] && st_off))
    else $error("shutdown not taken");

  chk_sw_wake_flag: assert property (
    @(posedge clk) disable iff (rst)
    (sw_wake && !any_off && !any_reset)
    |=> (wake_req && on_src_reg[ON_SW_WAKE]))
    else $error("software wake not taken");

  chk_reset_flags: assert property (
    @(posedge clk) disable iff (rst)
    (t_r_hw) |=> (off_req && on_src_reg[ON_HW_RST]))
    else $error("hardware reset not recorded");

  chk_seq_fail_off: assert property (
    @(posedge clk) disable iff (rst)
    (seq_fail_evt && !st_off && !any_reset)
    |=> (off_src_reg[OFF_SEQ] && st_off))
    else $error("sequence failure not recorded");

endmodule

// ==== testbench/pser_src_model.sv ====
`timescale 1ns/1ps

module pser_src_model (
  // Clock
  input wire logic clk,
  // Source pulses and button pin
  output logic [14:0] evt,
  output logic button_n
);
  initial
  begin
    evt = 15'h0000;
    button_n = 1'b1;
  end

  // ---------------------------------------------------------------
  // Source activity
  // ---------------------------------------------------------------
  // Index 15 is the button; a random hold exercises short and long presses
  task automatic pulse(input int i);
    int hold;
    begin
      hold = 3 + ($urandom % 4);
      @(posedge clk);
      if (i < 15)
        evt[i] <= 1'b1;
      else
        button_n <= 1'b0;
      @(posedge clk);
      evt <= 15'h0000;
      if (i == 15)
      begin
        repeat (hold) @(posedge clk);
        // Pin has a pull-up, so a released button reads high
        button_n <= 1'b1;
      end
    end
  endtask
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps

module testbench;
  import pser_pkg::*;
  logic clk, rst, reg_wr, reg_rd, supply_ok, charging;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, v, offv;
  logic [3:0] seen;
  logic seen_clr;
  wire logic [15:0] reg_rdata;
  wire logic on_req, wake_req, off_req, sleep_req, button_n;
  wire logic [2:0] power_state;
  wire logic [14:0] evt;
  int mismatches, checked, k, lastw;
  int wsrc[8] = '{5, 6, 0, 7, 3, 8, 15, -1};
  logic [15:0] wcfg[8] = '{16'h1, 16'h9, 16'h1, 16'h21, 16'h1, 16'h41,
                           16'h2, 16'h1};
  int wbit[8] = '{8, 7, 5, 9, 11, 10, 4, 6};
  int osrc[8] = '{-1, 15, 10, 8, 9, 2, 11, 12};
  logic [15:0] ocfg[8] = '{16'h1, 16'h4, 16'h1, 16'h81, 16'h1, 16'h1,
                           16'h1, 16'h1};
  int obit[8] = '{6, 4, 9, 10, 10, 11, 12, 13};
  int rsrc[4] = '{13, 14, 6, -1};
  logic [15:0] rcfg[4] = '{16'h1, 16'h1, 16'h11, 16'h1};
  int rbit[4] = '{1, 3, 0, 2};

  pser_src_model src_u (.clk(clk), .evt(evt), .button_n(button_n));

  pser_router dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .alarm_evt(evt[0]), .gpio_on_req(evt[1]), .gpio_off_req(evt[2]),
    .gpio_wake_req(evt[3]), .gpio_sleep_req(evt[4]),
    .charger_evt(evt[5]), .wdog_timeout_evt(evt[6]),
    .pen_down_evt(evt[7]), .supply_low_evt(evt[8]),
    .supply_shutdown_evt(evt[9]), .thermal_evt(evt[10]),
    .seq_fail_evt(evt[11]), .int_reg_fault_evt(evt[12]),
    .hw_reset_evt(evt[13]), .cnv_uv_reset_evt(evt[14]),
    .supply_ok(supply_ok), .charging(charging), .button_n(button_n),
    .on_req(on_req), .wake_req(wake_req), .off_req(off_req),
    .sleep_req(sleep_req), .power_state(power_state)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Sticky record of request pulses, cleared while seen_clr is high
  always @(posedge clk)
    seen <= seen_clr ? 4'h0 : (seen | {on_req, wake_req, off_req, sleep_req});

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] flag(input int b);
    return 16'h0001 << b;
  endfunction

  task automatic cmp(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Read data stand only in the cycle after the strobe
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Negative src means a control write of wval instead of a source pulse
  task automatic ev(input int src, input logic [15:0] cfg,
                    input logic [15:0] wval, input logic [3:0] ereq,
                    input logic [3:0] ra, input logic [15:0] esrc,
                    input logic [2:0] est);
    logic [15:0] d;
    begin
      wr(ADDR_CFG, cfg);
      seen_clr <= 1'b1;
      @(posedge clk);
      seen_clr <= 1'b0;
      if (src < 0)
        wr(ADDR_CTRL, wval);
      else
        src_u.pulse(src);
      repeat (10) @(posedge clk);
      #1;
      cmp("requests", {12'h000, ereq}, {12'h000, seen});
      cmp("state", {13'h0, est}, {13'h0, power_state});
      rd(ra, d);
      cmp("source", esrc, d);
      rd(ADDR_STATE, d);
      cmp("state reg", {13'h0, est}, d);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    supply_ok = 1'b0;
    charging = 1'b0;
    seen_clr = 1'b0;
    offv = 16'h0000;
    void'($urandom(65712));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CTRL, v);
    cmp("ctrl", CTRL_RESET_VAL, v);
    rd(ADDR_CFG, v);
    cmp("cfg", CFG_RESET_VAL, v);
    for (int i = 0; i < 4; i++)
    begin
      k = 5 + ($urandom % 11);
      wr(k[3:0], 16'($urandom));
      rd(k[3:0], v);
      cmp("unmapped", ZERO16, v);
    end
    ev(0, 16'h1, 0, 4'h0, ADDR_ON_SRC, ZERO16, PSER_OFF);
    supply_ok <= 1'b1;
    ev(0, 16'h1, 0, 4'h8, ADDR_ON_SRC, 16'h8020, PSER_ON);
    ev(-1, 16'h1, 16'h3, 4'h1, ADDR_OFF_SRC, ZERO16, PSER_SLEEP);
    for (int i = 0; i < 10; i++)
    begin
      lastw = $urandom % 8;
      ev(wsrc[lastw], wcfg[lastw], 16'h1, 4'h4, ADDR_ON_SRC,
         flag(wbit[lastw]), PSER_ON);
      ev(4, 16'h1, 0, 4'h1, ADDR_OFF_SRC, ZERO16, PSER_SLEEP);
    end
    ev(7, 16'h1, 0, 4'h0, ADDR_ON_SRC, flag(wbit[lastw]), PSER_SLEEP);
    for (int i = 0; i < 8; i++)
    begin
      ev(wsrc[i], wcfg[i], 16'h1, 4'h4, ADDR_ON_SRC, flag(wbit[i]),
         PSER_ON);
      ev(4, 16'h1, 0, 4'h1, ADDR_OFF_SRC, ZERO16, PSER_SLEEP);
    end
    ev(5, 16'h1, 0, 4'h4, ADDR_ON_SRC, flag(ON_CHARGER), PSER_ON);
    for (int i = 0; i < 8; i++)
    begin
      offv = flag(obit[i]);
      ev(osrc[i], ocfg[i], 16'h0, 4'h2, ADDR_OFF_SRC, offv,
         PSER_OFF);
      if (i % 2 == 0)
        ev(1, 16'h1, 0, 4'h8, ADDR_ON_SRC, 16'h8800, PSER_ON);
      else
        ev(15, 16'h1, 0, 4'h8, ADDR_ON_SRC, 16'h8010, PSER_ON);
    end
    charging <= 1'b1;
    ev(2, 16'h101, 0, 4'h0, ADDR_OFF_SRC, offv, PSER_ON);
    ev(15, 16'h104, 0, 4'h0, ADDR_OFF_SRC, offv, PSER_ON);
    ev(-1, 16'h101, 16'h0, 4'h0, ADDR_OFF_SRC, offv, PSER_ON);
    charging <= 1'b0;
    for (int i = 0; i < 4; i++)
      ev(rsrc[i], rcfg[i], 16'h5, 4'ha, ADDR_ON_SRC, flag(rbit[i]),
         PSER_ON);
    complete_run;
  end

  // Hang guard, well beyond the roughly 1400 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run;
  end
endmodule
